//--- ofm_pkg.sv
// Constants, types and the ordering tables of the image output formatter.
// Assumes one 16-pixel pair of kernels is presented per array read.
package ofm_pkg;

    localparam int PIX_W    = 10;
    localparam int ROW_W    = 10;
    localparam int LANES    = 4;
    localparam int GRP_PIX  = 8;
    localparam int PAIR_PIX = 16;
    localparam int CNT_W    = 16;
    localparam int GRP_W    = 9;
    localparam int OUT_MSPS = 62;

    localparam logic [PIX_W-1:0] TRAIN_PAT = 10'h03A6;
    localparam logic [PIX_W-1:0] CRC_POLY  = 10'h024F;
    localparam logic [PIX_W-1:0] SEED_ONES = 10'h03FF;
    localparam logic [PIX_W-1:0] SEED_ZERO = 10'h0000;

    // Position tables: nibble i is the pair position of output slot i
    localparam logic [31:0] POS_EVEN = 32'h7654_3210;
    localparam logic [31:0] POS_ODD  = 32'h89AB_CDEF;
    localparam logic [31:0] POS_MONO = 32'hECA8_6420;
    localparam logic [31:0] POS_COL  = 32'hDC98_5410;

    typedef logic [PAIR_PIX-1:0][PIX_W-1:0] ofm_pair_t;
    typedef logic [LANES-1:0][PIX_W-1:0]    ofm_lanes_t;

    typedef struct packed {
        logic             run;
        logic             parallel;
        logic             subsample;
        logic             colour;
        logic             black_line_frame_strobe_on;
        logic             black_line_row_strobe_on;
        logic             crc_seed_ones;
        logic [ROW_W-1:0] region0_first_row;
        logic [ROW_W-1:0] region0_last_row;
        logic [ROW_W-1:0] region1_first_row;
        logic [ROW_W-1:0] region1_last_row;
    } ofm_cfg_t;

    typedef struct packed {
        logic             black;
        logic [ROW_W-1:0] row;
        logic [GRP_W-1:0] pair;
    } ofm_arr_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FOT  = 3'b001,
        ST_CHK  = 3'b010,
        ST_LINE = 3'b011,
        ST_CRC  = 3'b100,
        ST_ROT  = 3'b101
    } ofm_state_t;

endpackage : ofm_pkg

//--- ofm_sync.sv
// Three-flop level synchroniser with agreement filter.
// Assumes the source holds a level for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module ofm_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk,
    // Level in, filtered level out
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk)
    begin
        s1_q <= d;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (s2_q == s3_q)
            q <= s3_q;
    end
endmodule : ofm_sync
`default_nettype wire

//--- ofm_crc.sv
// Per-stream ten-bit line CRC.
// Assumes the caller clears it at line start and feeds only valid words.
`timescale 1ns/1ps
`default_nettype none
module ofm_crc
(
    // Clock, reset, advance
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 adv,
    // Control
    input  wire logic                 clr,
    input  wire logic                 seed_ones,
    input  wire logic                 upd,
    // Word in, code out
    input  wire logic [ofm_pkg::PIX_W-1:0] din,
    output var  logic [ofm_pkg::PIX_W-1:0] crc_q
);
    import ofm_pkg::*;

    function automatic logic [PIX_W-1:0] step(input logic [PIX_W-1:0] c,
                                              input logic [PIX_W-1:0] d);
        logic [PIX_W-1:0] r;
        logic             fb;
        r = c;
        for (int b = PIX_W - 1; b >= 0; b--)
        begin
            fb = r[PIX_W-1] ^ d[b];
            r  = {r[PIX_W-2:0], 1'b0} ^ (fb ? CRC_POLY : SEED_ZERO);
        end
        return r;
    endfunction : step

    always_ff @(posedge clk)
    begin
        if (rst)
            crc_q <= SEED_ZERO;
        else if (adv && clr)
            crc_q <= seed_ones ? SEED_ONES : SEED_ZERO;
        else if (adv && upd)
            crc_q <= step(crc_q, din);
    end
endmodule : ofm_crc
`default_nettype wire

//--- ofm_formatter.sv
// Image output formatter: kernel ordering, framing strobes and line CRC.
// Assumes the pixel array answers its read request combinationally on pix_clk.
`timescale 1ns/1ps
`default_nettype none
module ofm_formatter #(
    parameter int PAIRS       = 80,
    parameter int BLACK_LINES = 2,
    parameter int FOT_CYC     = 64,
    parameter int ROT_CYC     = 16
) (
    // Control clock domain
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    // Configuration
    input  wire ofm_pkg::ofm_cfg_t       cfg_in,
    input  wire logic                    cfg_load,
    output var  logic                    cfg_busy,
    // Pixel clock domain
    input  wire logic                    pix_clk,
    // Pixel array read
    output var  ofm_pkg::ofm_arr_req_t   arr_req,
    input  wire ofm_pkg::ofm_pair_t      arr_pix,
    // Parallel output
    output var  logic                    out_clk,
    output var  logic [ofm_pkg::PIX_W-1:0] out_data,
    output var  logic                    frame_valid,
    output var  logic                    line_valid,
    // Serial lane words
    output var  ofm_pkg::ofm_lanes_t     lane_data
);
    import ofm_pkg::*;

    localparam logic [ROW_W-1:0] BLK_N    = ROW_W'(BLACK_LINES);
    localparam logic [CNT_W-1:0] FOT_LAST = CNT_W'(FOT_CYC - 1);
    localparam logic [CNT_W-1:0] ROT_LAST = CNT_W'(ROT_CYC - 1);
    localparam logic [GRP_W-1:0] GRP_SUB  = GRP_W'(PAIRS - 1);
    localparam logic [GRP_W-1:0] GRP_FULL = GRP_W'(2 * PAIRS - 1);
    localparam logic [2:0]       STP_PAR  = 3'h7;
    localparam logic [2:0]       STP_SER  = 3'h1;

    // ************************************************************
    // Control domain: configuration handshake
    // ************************************************************
    ofm_cfg_t shadow_q;
    logic     req_q;
    logic     ack_c;
    logic     busy_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            shadow_q <= '0;
            req_q    <= 1'b0;
        end
        else if (clk_en && cfg_load && !busy_q && (req_q == ack_c))
        begin
            shadow_q <= cfg_in;
            req_q    <= ~req_q;
        end
    end

    // Shadow stays frozen until the pixel side has echoed the toggle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            busy_q <= 1'b0;
        else if (clk_en)
            busy_q <= (req_q != ack_c) || (cfg_load && !busy_q);
    end

    assign cfg_busy = busy_q;

    // ************************************************************
    // Crossings between the control and pixel domains
    // ************************************************************
    logic       ack_q;
    logic [2:0] xin_p;
    logic       rst_p;
    logic       ce_p;
    logic       req_p;

    ofm_sync #(.W(3)) u_sync_pix (
        .clk (pix_clk),
        .d   ({sys_rst, clk_en, req_q}),
        .q   (xin_p)
    );

    ofm_sync #(.W(1)) u_sync_ack (
        .clk (clk),
        .d   (ack_q),
        .q   (ack_c)
    );

    assign rst_p = xin_p[2];
    assign ce_p  = xin_p[1];
    assign req_p = xin_p[0];

    ofm_cfg_t cfg_q;
    ofm_cfg_t fcfg_q;

    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
        begin
            cfg_q <= '0;
            ack_q <= 1'b0;
        end
        else if (req_p != ack_q)
        begin
            cfg_q <= shadow_q;
            ack_q <= req_p;
        end
    end

    // ************************************************************
    // Output clock phase
    // ************************************************************
    logic ph_q;
    logic adv;

    // Words change as out_clk falls, so the receiver samples on its rise
    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
            ph_q <= 1'b0;
        else if (ce_p)
            ph_q <= ~ph_q;
    end

    assign adv     = ce_p && ph_q;
    assign out_clk = ph_q;

    // ************************************************************
    // Frame and line sequencer
    // ************************************************************
    ofm_state_t       st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ROW_W-1:0] row_q;
    logic             blk_q;
    logic [GRP_W-1:0] grp_q;
    logic [GRP_W-1:0] pair_q;
    logic [2:0]       stp_q;
    logic [ROW_W-1:0] first_row;
    logic [ROW_W-1:0] last_row;
    logic             in_region;
    logic [GRP_W-1:0] grp_last;
    logic [2:0]       stp_last;
    logic             grp_end;
    logic             line_end;
    logic [GRP_W-1:0] grp_nx;

    always_comb
    begin
        first_row = (fcfg_q.region0_first_row < fcfg_q.region1_first_row)
                  ? fcfg_q.region0_first_row : fcfg_q.region1_first_row;
        last_row  = (fcfg_q.region0_last_row > fcfg_q.region1_last_row)
                  ? fcfg_q.region0_last_row : fcfg_q.region1_last_row;
        in_region = ((row_q >= fcfg_q.region0_first_row) && (row_q <= fcfg_q.region0_last_row))
                 || ((row_q >= fcfg_q.region1_first_row) && (row_q <= fcfg_q.region1_last_row));
    end

    assign grp_last = fcfg_q.subsample ? GRP_SUB : GRP_FULL;
    assign stp_last = fcfg_q.parallel ? STP_PAR : STP_SER;
    assign grp_end  = (stp_q == stp_last);
    assign line_end = grp_end && (grp_q == grp_last);
    assign grp_nx   = grp_q + 1'b1;

    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
        begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            row_q  <= '0;
            blk_q  <= 1'b0;
            fcfg_q <= '0;
        end
        else if (adv)
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (cfg_q.run)
                    begin
                        fcfg_q <= cfg_q;
                        st_q   <= ST_FOT;
                    end
                end
                ST_FOT:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == FOT_LAST)
                    begin
                        blk_q <= (BLK_N != '0);
                        row_q <= '0;
                        st_q  <= ST_CHK;
                    end
                end
                ST_CHK:
                begin
                    cnt_q <= '0;
                    if (blk_q && (row_q == BLK_N))
                    begin
                        blk_q <= 1'b0;
                        row_q <= first_row;
                    end
                    else if (blk_q || (in_region && row_q <= last_row))
                        st_q <= ST_LINE;
                    else if (row_q > last_row)
                        st_q <= ST_IDLE;
                    else
                        row_q <= row_q + 1'b1;
                end
                ST_LINE:
                begin
                    if (line_end)
                        st_q <= ST_CRC;
                end
                ST_CRC:
                    st_q <= ST_ROT;
                ST_ROT:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == ROT_LAST)
                    begin
                        row_q <= row_q + 1'b1;
                        st_q  <= ST_CHK;
                    end
                end
            endcase
        end
    end

    // Kernel walk along the line, left to right
    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
        begin
            grp_q  <= '0;
            pair_q <= '0;
            stp_q  <= '0;
        end
        else if (adv)
        begin
            if (st_q != ST_LINE || line_end)
            begin
                grp_q  <= '0;
                pair_q <= '0;
                stp_q  <= '0;
            end
            else if (grp_end)
            begin
                stp_q  <= '0;
                grp_q  <= grp_nx;
                pair_q <= fcfg_q.subsample ? grp_nx : (grp_nx >> 1);
            end
            else
                stp_q <= stp_q + 1'b1;
        end
    end

    assign arr_req = '{black: blk_q, row: row_q, pair: pair_q};

    // ************************************************************
    // Pixel selection
    // ************************************************************
    logic [31:0]                  pos_tab;
    logic [GRP_PIX-1:0][PIX_W-1:0] sel;
    ofm_lanes_t                   lane_d;
    logic [LANES-1:0][PIX_W-1:0]  crc;
    ofm_lanes_t                   word_d;
    logic                         in_line;

    always_comb
    begin
        if (fcfg_q.subsample)
            pos_tab = fcfg_q.colour ? POS_COL : POS_MONO;
        else
            pos_tab = grp_q[0] ? POS_ODD : POS_EVEN;
    end

    assign in_line = (st_q == ST_LINE);

    genvar gi;
    generate
        for (gi = 0; gi < GRP_PIX; gi++)
        begin : g_sel
            assign sel[gi] = arr_pix[pos_tab[4*gi +: 4]];
        end
        for (gi = 0; gi < LANES; gi++)
        begin : g_lane
            // In serial mode lane k carries slots 2k and 2k+1 in turn
            if (gi == 0)
            begin : g_first
                assign lane_d[gi] = fcfg_q.parallel ? sel[stp_q]
                                  : sel[{2'(gi), stp_q[0]}];
            end
            else
            begin : g_rest
                assign lane_d[gi] = fcfg_q.parallel ? TRAIN_PAT
                                  : sel[{2'(gi), stp_q[0]}];
            end

            ofm_crc u_crc (
                .clk       (pix_clk),
                .rst       (rst_p),
                .adv       (adv),
                .clr       (st_q == ST_CHK),
                .seed_ones (fcfg_q.crc_seed_ones),
                .upd       (in_line),
                .din       (lane_d[gi]),
                .crc_q     (crc[gi])
            );

            always_comb
            begin
                if (in_line)
                    word_d[gi] = lane_d[gi];
                else if (st_q == ST_CRC)
                    word_d[gi] = crc[gi];
                else
                    word_d[gi] = TRAIN_PAT;
            end
        end
    endgenerate

    // ************************************************************
    // Output registers
    // ************************************************************
    logic [PIX_W-1:0] data_q;
    ofm_lanes_t       lanes_q;
    logic             fval_q;
    logic             lval_q;
    logic             fval_on;

    // Full ten-bit words only; no window id ever enters the stream
    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
        begin
            data_q  <= TRAIN_PAT;
            lanes_q <= {LANES{TRAIN_PAT}};
        end
        else if (adv)
        begin
            data_q  <= word_d[0];
            lanes_q <= word_d;
        end
    end

    // Black lines raise frame-valid only when their frame strobe is on
    assign fval_on = !blk_q || fcfg_q.black_line_frame_strobe_on;

    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
            fval_q <= 1'b0;
        else if (adv)
        begin
            if (st_q == ST_IDLE)
                fval_q <= 1'b0;
            else if (st_q == ST_CHK && row_q > last_row && !blk_q)
                fval_q <= 1'b0;
            else if (st_q == ST_CHK && fval_on && (blk_q ? row_q != BLK_N : in_region))
                fval_q <= 1'b1;
            else if (st_q == ST_CHK && !fval_on)
                fval_q <= 1'b0;
        end
    end

    always_ff @(posedge pix_clk)
    begin
        if (rst_p)
            lval_q <= 1'b0;
        else if (adv)
            lval_q <= in_line && (!blk_q || fcfg_q.black_line_row_strobe_on);
    end

    assign out_data    = data_q;
    assign lane_data   = lanes_q;
    assign frame_valid = fval_q;
    assign line_valid  = lval_q;

endmodule : ofm_formatter
`default_nettype wire

//--- ofm_formatter_properties.sv
// Concurrent checks on the formatter's top-level ports.
// Assumes clk_en held high and cfg_in changed only while idle.
`timescale 1ns/1ps
`default_nettype none
module ofm_formatter_properties
    import ofm_pkg::*;
#(
    parameter int PAIRS = 80
) (
    // Control domain
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic                      clk_en,
    input wire ofm_pkg::ofm_cfg_t         cfg_in,
    input wire logic                      cfg_load,
    input wire logic                      cfg_busy,
    // Pixel domain
    input wire logic                      pix_clk,
    input wire ofm_pkg::ofm_arr_req_t     arr_req,
    input wire logic                      out_clk,
    input wire logic [ofm_pkg::PIX_W-1:0] out_data,
    input wire logic                      frame_valid,
    input wire logic                      line_valid
);
    // ****************
    // Assertions
    // ****************
    chk_busy_on_load: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_load && clk_en && !cfg_busy |=> cfg_busy)
        else $error("cfg_busy did not rise after a load");
    chk_busy_bounded: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(cfg_busy) |-> ##[1:40] !cfg_busy)
        else $error("cfg_busy stuck high");
    chk_clk_half_rate: assert property (@(posedge pix_clk) disable iff (sys_rst)
        $past(out_clk) |-> !out_clk)
        else $error("out_clk high for two pixel clocks");
    chk_word_on_fall: assert property (@(posedge pix_clk) disable iff (sys_rst)
        $changed({out_data, frame_valid, line_valid}) |-> $fell(out_clk))
        else $error("output word changed away from out_clk fall");
    chk_crc_then_idle: assert property (@(posedge pix_clk) disable iff (sys_rst)
        $fell(line_valid) |-> ##2 out_data == TRAIN_PAT)
        else $error("no training word after the line code");
    chk_line_min_len: assert property (@(posedge pix_clk) disable iff (sys_rst)
        $rose(line_valid) |-> line_valid [*8])
        else $error("line_valid pulse too short");
    chk_fv_covers_lv: assert property (@(posedge pix_clk) disable iff (sys_rst)
        line_valid && !frame_valid |-> !cfg_in.black_line_frame_strobe_on
        && cfg_in.black_line_row_strobe_on)
        else $error("line_valid outside frame_valid");
    chk_pair_range: assert property (@(posedge pix_clk) disable iff (sys_rst)
        arr_req.pair < PAIRS)
        else $error("pair request out of range");
    // Reset check cannot be disabled by the reset it watches
    chk_reset_idle: assert property (@(posedge pix_clk)
        sys_rst [*8] ##1 sys_rst |-> out_data == TRAIN_PAT && !frame_valid
        && !line_valid && !out_clk)
        else $error("outputs not idle in reset");
    cov_frame: cover property (@(posedge pix_clk) $rose(frame_valid));
    cov_line: cover property (@(posedge pix_clk) $fell(line_valid));
    cov_load: cover property (@(posedge clk) $rose(cfg_busy));
endmodule : ofm_formatter_properties

bind ofm_formatter ofm_formatter_properties #(.PAIRS(PAIRS)) u_props (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg_in(cfg_in),
    .cfg_load(cfg_load), .cfg_busy(cfg_busy), .pix_clk(pix_clk),
    .arr_req(arr_req), .out_clk(out_clk), .out_data(out_data),
    .frame_valid(frame_valid), .line_valid(line_valid));
`default_nettype wire

//--- ofm_array_model.sv
// Pixel array model: coded pixels for each read request.
// Assumes the formatter samples the answer in the request cycle.
`timescale 1ns/1ps
`default_nettype none
module ofm_array_model
    import ofm_pkg::*;
(
    // Read port
    input  wire ofm_pkg::ofm_arr_req_t arr_req,
    output var  ofm_pkg::ofm_pair_t    arr_pix
);
    // Code: black flag, low row bits, position; black rows read as row 0
    always_comb
    begin
        for (int i = 0; i < PAIR_PIX; i++)
            arr_pix[i] = {arr_req.black, arr_req.row[4:0] & {5{~arr_req.black}}, 4'(i)};
    end
endmodule : ofm_array_model
`default_nettype wire

//--- image_output_formatter_test.sv
// Testbench: mode table through framing, order and line code.
// Assumes ofm_pkg, ofm_formatter and ofm_array_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module image_output_formatter_test;
    import ofm_pkg::*;
    typedef struct packed {
        logic sub, col, bfs, brs, seed, ser;
        logic [63:0] pos;
        logic [15:0] p3;
        logic [4:0] n;
    } ofm_tb_row_t;
    // Mono subsample, colour subsample, both full orders, one serial row
    // Serial: pos is lane 0, p3 is lane 3 (slots 2k, 2k+1 per kernel)
    ofm_tb_row_t rows [5] = '{
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 64'h89AB_CDEF_7654_3210, 16'h0000, 5'h10},
        '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 64'h0000_0000_ECA8_6420, 16'h0000, 5'h08},
        '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 64'h0000_0000_DC98_5410, 16'h0000, 5'h08},
        '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 64'h89AB_CDEF_7654_3210, 16'h0000, 5'h10},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 64'h0000_0000_0000_EF10, 16'h8976, 5'h04}};
    logic clk = 0, pix_clk = 0, sys_rst = 1, cfg_load = 0, lv_q = 0;
    logic out_clk, frame_valid, line_valid, cfg_busy;
    logic [PIX_W-1:0] out_data;
    logic [PIX_W-1:0] lw [8][16];
    logic [PIX_W-1:0] lw3 [8][16];
    ofm_lanes_t lane_data;
    logic [PIX_W-1:0] lcrc [8];
    logic lfv [8];
    int lnw [8];
    int err_total = 0, n_checks = 0, ln = 0, wn = 0;
    ofm_cfg_t cfg_in = '0;
    ofm_arr_req_t arr_req;
    ofm_pair_t arr_pix;

    always #12.5 clk = ~clk;
    always #6 pix_clk = ~pix_clk;

    ofm_formatter #(.PAIRS(1), .BLACK_LINES(1), .FOT_CYC(4), .ROT_CYC(2)) DUT (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .cfg_in(cfg_in),
        .cfg_load(cfg_load), .cfg_busy(cfg_busy), .pix_clk(pix_clk),
        .arr_req(arr_req), .arr_pix(arr_pix), .out_clk(out_clk),
        .out_data(out_data), .frame_valid(frame_valid),
        .line_valid(line_valid), .lane_data(lane_data));
    ofm_array_model u_array (.arr_req(arr_req), .arr_pix(arr_pix));

    // ****************
    // Receiver: samples on forwarded clock
    // ****************
    always @(posedge out_clk)
    begin
        if (line_valid && ln < 8)
        begin
            if (wn < 16)
            begin
                lw[ln][wn] = out_data;
                lw3[ln][wn] = lane_data[3];
            end
            wn++;
            lfv[ln] = frame_valid;
        end
        else if (lv_q && ln < 8)
        begin
            lcrc[ln] = out_data;
            lnw[ln] = wn;
            ln++;
            wn = 0;
        end
        lv_q = line_valid;
    end

    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    function automatic ofm_cfg_t mk(input logic run, input ofm_tb_row_t r);
        return {run, ~r.ser, r.sub, r.col, r.bfs, r.brs, r.seed,
                10'h002, 10'h003, 10'h003, 10'h004};
    endfunction : mk

    function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d);
        logic fb;
        for (int i = 9; i >= 0; i--)
        begin
            fb = c[9] ^ d[i];
            c = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
        end
        return c;
    endfunction : crc_step

    task automatic load(input ofm_cfg_t c);
        @(posedge clk);
        cfg_in <= c;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(negedge clk);
        check(cfg_busy, 16'h0001);
        for (int i = 0; i < 200 && cfg_busy !== 1'b0; i++)
            @(negedge clk);
        check(cfg_busy, 16'h0000);
    endtask : load

    task automatic check_line(input ofm_tb_row_t r, input int k);
        logic blk;
        logic [9:0] row, exp, crc;
        blk = r.brs && k == 0;
        row = blk ? 10'h000 : 10'(2 + k - r.brs);
        crc = r.seed ? SEED_ONES : SEED_ZERO;
        check(16'(lnw[k]), r.n);
        check(lfv[k], blk ? r.bfs : 1'b1);
        for (int j = 0; j < r.n; j++)
        begin
            exp = {blk, row[4:0], r.pos[4*j +: 4]};
            check(lw[k][j], exp);
            check(lw3[k][j], r.ser ? {blk, row[4:0], r.p3[4*(j%4) +: 4]} : TRAIN_PAT);
            crc = crc_step(crc, exp);
        end
        check(lcrc[k], crc);
    endtask : check_line

    // ****************
    // Sequence
    // ****************
    initial
    begin
        #400us;
        err_total++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[m])
        begin
            ln = 0;
            wn = 0;
            load(mk(1'b1, rows[m]));
            for (int i = 0; i < 3000 && ln < 3 + rows[m].brs; i++)
                @(posedge clk);
            load(mk(1'b0, rows[m]));
            repeat (400) @(negedge clk);
            check(out_data, TRAIN_PAT);
            check(frame_valid, 16'h0000);
            check(16'(ln >= 3 + rows[m].brs), 16'h0001);
            for (int k = 0; k < 3 + rows[m].brs; k++)
                check_line(rows[m], k);
        end
        // Reset in mid-frame drops strobes and returns to training
        load(mk(1'b1, rows[0]));
        repeat (30) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check(out_data, TRAIN_PAT);
        check({out_clk, frame_valid, line_valid, cfg_busy}, 16'h0000);
        // Release and run one frame; receiver state is cleared once pix side runs
        @(posedge clk);
        sys_rst <= 1'b0;
        load(mk(1'b1, rows[1]));
        ln = 0;
        wn = 0;
        for (int i = 0; i < 3000 && ln < 3; i++)
            @(posedge clk);
        for (int k = 0; k < 3; k++)
            check_line(rows[1], k);
        end_sim();
    end
endmodule : image_output_formatter_test
`default_nettype wire
